// File: ptu_pkg.sv
// Purpose : Shared constants for the pulse timer unit channel and its bus controller
// Assumes : One 100 MHz clock, asynchronous active-high reset
// Notes   : Device register indices are word indices on the two-state link bus
package ptu_pkg;
    // -------------------------------------------------------------------------
    // Widths
    // -------------------------------------------------------------------------
    localparam int DW = 16;
    localparam int AW = 3;
    localparam int WBW = 32;

    // -------------------------------------------------------------------------
    // Device registers on the link bus
    // -------------------------------------------------------------------------
    localparam logic [AW-1:0] DEV_CTRL   = 3'h0;
    localparam logic [AW-1:0] DEV_COUNT  = 3'h1;
    localparam logic [AW-1:0] DEV_MATCH  = 3'h2;
    localparam logic [AW-1:0] DEV_BUFFER = 3'h3;
    localparam logic [AW-1:0] DEV_STATUS = 3'h4;
    localparam logic [AW-1:0] DEV_IRQEN  = 3'h5;

    // Control fields
    localparam int CTL_CLKSEL_LO = 0;
    localparam int CTL_DOWN      = 2;
    localparam int CTL_CLR_MATCH = 3;
    localparam int CTL_CLR_CAPT  = 4;
    localparam int CTL_CAPT_MODE = 5;
    localparam int CTL_BUF_EN    = 6;
    localparam int CTL_PIN_OE    = 7;
    localparam int CTL_RUN       = 8;
    localparam int CTL_W         = 9;

    // Clock source select
    localparam logic [1:0] CLK_INTERNAL = 2'h0;
    localparam logic [1:0] CLK_EXT_ONE  = 2'h1;
    localparam logic [1:0] CLK_EXT_BOTH = 2'h2;
    localparam logic [1:0] CLK_PHASE    = 2'h3;

    // Status and enable fields
    localparam int ST_MATCH = 0;
    localparam int ST_OVF   = 1;
    localparam int ST_UNF   = 2;
    localparam int ST_W     = 3;

    localparam logic [DW-1:0] CNT_MAX   = 16'hFFFF;
    localparam logic [DW-1:0] CNT_ZERO  = 16'h0000;
    localparam logic [DW-1:0] MATCH_RST = 16'hFFFF;
    localparam logic [3:0]    PRESCALE  = 4'h3;

    // -------------------------------------------------------------------------
    // Controller Wishbone map (byte addresses)
    // -------------------------------------------------------------------------
    localparam logic [7:0] WB_CMD    = 8'h00;
    localparam logic [7:0] WB_WDATA  = 8'h04;
    localparam logic [7:0] WB_RDATA  = 8'h08;
    localparam logic [7:0] WB_ISTAT  = 8'h0C;
    localparam logic [7:0] WB_IMASK  = 8'h10;
    localparam logic [7:0] WB_PINS   = 8'h14;
    localparam logic [7:0] WB_STATE  = 8'h18;

    localparam int CMD_GO     = 0;
    localparam int CMD_WE     = 1;
    localparam int CMD_ADR_LO = 2;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_DEV    = 1;
    localparam int IRQ_W      = 2;
    localparam int PIN_A      = 0;
    localparam int PIN_B      = 1;
    localparam int PIN_CAP    = 2;
    localparam int PIN_STOP   = 3;
    localparam int PIN_W      = 4;
endpackage

// File: ptu_link_if.sv
// Purpose : Link between the timer channel and its bus controller
// Assumes : Both ends on ref_clk; one bus state per clock cycle
// Notes   : busFirst and busSecond mark the two states of a register access
`timescale 1ns/1ns
interface ptu_link_if;
    logic                   busFirst;
    logic                   busSecond;
    logic                   busWe;
    logic [ptu_pkg::AW-1:0] busAddr;
    logic [ptu_pkg::DW-1:0] busWdata;
    logic [ptu_pkg::DW-1:0] busRdata;
    logic                   extClockInA;
    logic                   extClockInB;
    logic                   captureIn;
    logic                   moduleStop;
    logic                   matchPinOut;
    logic                   matchPinOe;
    logic                   chanIrq;

    modport dev (
        input  busFirst, busSecond, busWe, busAddr, busWdata,
        input  extClockInA, extClockInB, captureIn, moduleStop,
        output busRdata, matchPinOut, matchPinOe, chanIrq
    );
    modport host (
        output busFirst, busSecond, busWe, busAddr, busWdata,
        output extClockInA, extClockInB, captureIn, moduleStop,
        input  busRdata, matchPinOut, matchPinOe, chanIrq
    );
endinterface // ptu_link_if

// File: ptu_dev_end.sv
// What this block does
// - Outside clock pulses last 1.5 or 2.5 states
// - Phase inputs keep 1.5 offset, 2.5 width
// - Clear on final match state, period N+1
// - Clear beats counter write in second state
// - Counter write beats increment in second state
// - Match register write suppresses coinciding match
// - Match transfer uses buffer value before write
// - Capture in first read state returns new
// - Capture beats match register write
// - Capture buffer shift beats buffer write
// - Clear beats overflow/underflow, flags untouched
// - Counter write suppresses overflow/underflow flags
// - No match output on shared clock pin; match output still drives it under CTL_PIN_OE, clock input A held at zero
// - Disable interrupts before entering module stop
// - Interrupt while flag and enable both set
// - One match per counter input clock
//
// Purpose : One timer channel: counter, match/capture, buffer, flags, interrupt
// Assumes : Pin inputs synchronous to ref_clk; host sequences the two bus states
// Notes   : Status bits clear by writing 0 after reading 1; set wins over clear
`timescale 1ns/1ns
module ptu_dev_end (
    input wire logic ref_clk,
    input wire logic rst,
    ptu_link_if.dev  link
);
    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    logic [ptu_pkg::CTL_W-1:0] ctrl_q;
    logic [ptu_pkg::DW-1:0]    count_q;
    logic [ptu_pkg::DW-1:0]    match_q;
    logic [ptu_pkg::DW-1:0]    buffer_q;
    logic [ptu_pkg::ST_W-1:0]  status_q;
    logic [ptu_pkg::ST_W-1:0]  irqEn_q;
    logic [ptu_pkg::DW-1:0]    rdata_q;
    logic                      pinOut_q;
    logic                      pinOe_q;
    logic                      irq_q;
    logic [3:0]                presc_q;
    logic                      prevA_q;
    logic                      prevB_q;
    logic                      prevCap_q;

    // Register hit in the second state of a write
    function automatic logic wrHit(input logic [ptu_pkg::AW-1:0] a);
        wrHit = link.busSecond && link.busWe && (link.busAddr == a);
    endfunction

    // -------------------------------------------------------------------------
    // Count source
    // -------------------------------------------------------------------------
    logic       run;
    logic       aRise;
    logic       aFall;
    logic       bRise;
    logic       bFall;
    logic       phaseUp;
    logic       tick;
    logic       down;
    logic       capEv;
    logic       eq;
    logic       matchEv;
    logic       clrEv;
    logic       cntWr;
    logic       wrap;

    assign run   = ctrl_q[ptu_pkg::CTL_RUN] && !link.moduleStop;
    assign aRise = link.extClockInA && !prevA_q;
    assign aFall = !link.extClockInA && prevA_q;
    assign bRise = link.extClockInB && !prevB_q;
    assign bFall = !link.extClockInB && prevB_q;
    // Quadrature direction from which input leads
    assign phaseUp = (aRise && !link.extClockInB) || (aFall && link.extClockInB)
                  || (bRise && link.extClockInA) || (bFall && !link.extClockInA);

    // Edges are sampled once a cycle, so a pulse held for a single cycle is still counted; the stated widths are not checked
    always_comb begin
        tick = 1'b0;
        down = ctrl_q[ptu_pkg::CTL_DOWN];
        case (ctrl_q[ptu_pkg::CTL_CLKSEL_LO +: 2])
            ptu_pkg::CLK_INTERNAL: tick = (presc_q == ptu_pkg::PRESCALE);
            ptu_pkg::CLK_EXT_ONE:  tick = aRise;
            ptu_pkg::CLK_EXT_BOTH: tick = aRise || aFall;
            ptu_pkg::CLK_PHASE: begin
                tick = aRise || aFall || bRise || bFall;
                down = !phaseUp;
            end
            default: tick = 1'b0;
        endcase
        tick = tick && run;
    end

    // Divider and edge history
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            presc_q   <= 4'h0;
            prevA_q   <= 1'b0;
            prevB_q   <= 1'b0;
            prevCap_q <= 1'b0;
        end else begin
            presc_q   <= (presc_q == ptu_pkg::PRESCALE) ? 4'h0 : presc_q + 4'h1;
            prevA_q   <= link.extClockInA;
            prevB_q   <= link.extClockInB;
            prevCap_q <= link.captureIn;
        end
    end

    // -------------------------------------------------------------------------
    // Events and their arbitration
    // -------------------------------------------------------------------------
    assign capEv = run && ctrl_q[ptu_pkg::CTL_CAPT_MODE] && link.captureIn && !prevCap_q;
    assign eq    = (count_q == match_q);
    // Match only on a counter input clock, so at most one per clock
    assign matchEv = tick && eq && !ctrl_q[ptu_pkg::CTL_CAPT_MODE]
                  && !wrHit(ptu_pkg::DEV_MATCH);
    assign clrEv = (matchEv && ctrl_q[ptu_pkg::CTL_CLR_MATCH])
                || (capEv && ctrl_q[ptu_pkg::CTL_CLR_CAPT]);
    assign cntWr = wrHit(ptu_pkg::DEV_COUNT);
    assign wrap  = tick && (down ? (count_q == ptu_pkg::CNT_ZERO)
                                 : (count_q == ptu_pkg::CNT_MAX));

    // Counter: clear, then CPU write, then count
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_q <= ptu_pkg::CNT_ZERO;
        end else if (clrEv) begin
            count_q <= ptu_pkg::CNT_ZERO;
        end else if (cntWr) begin
            count_q <= link.busWdata;
        end else if (tick) begin
            count_q <= down ? count_q - 16'h0001 : count_q + 16'h0001;
        end
    end

    // Match/capture register: capture, then buffer transfer, then write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            match_q <= ptu_pkg::MATCH_RST;
        end else if (capEv) begin
            match_q <= count_q;
        end else if (matchEv && ctrl_q[ptu_pkg::CTL_BUF_EN]) begin
            match_q <= buffer_q;
        end else if (wrHit(ptu_pkg::DEV_MATCH)) begin
            match_q <= link.busWdata;
        end
    end

    // Buffer: capture shift wins over a CPU write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            buffer_q <= ptu_pkg::MATCH_RST;
        end else if (capEv && ctrl_q[ptu_pkg::CTL_BUF_EN]) begin
            buffer_q <= match_q;
        end else if (wrHit(ptu_pkg::DEV_BUFFER)) begin
            buffer_q <= link.busWdata;
        end
    end

    // Control and enables
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q  <= '0;
            irqEn_q <= '0;
        end else begin
            if (wrHit(ptu_pkg::DEV_CTRL)) begin
                ctrl_q <= link.busWdata[ptu_pkg::CTL_W-1:0];
            end
            if (wrHit(ptu_pkg::DEV_IRQEN)) begin
                irqEn_q <= link.busWdata[ptu_pkg::ST_W-1:0];
            end
        end
    end

    // -------------------------------------------------------------------------
    // Status flags
    // -------------------------------------------------------------------------
    logic [ptu_pkg::ST_W-1:0] setV;
    logic [ptu_pkg::ST_W-1:0] keepV;

    always_comb begin
        setV = '0;
        setV[ptu_pkg::ST_MATCH] = matchEv || capEv;
        // Neither a clear nor a counter write may raise a wrap flag
        setV[ptu_pkg::ST_OVF] = wrap && !down && !clrEv && !cntWr;
        setV[ptu_pkg::ST_UNF] = wrap && down && !clrEv && !cntWr;
        keepV = status_q;
        // A stopped module cannot have its flags cleared
        if (wrHit(ptu_pkg::DEV_STATUS) && !link.moduleStop) begin
            keepV = status_q & link.busWdata[ptu_pkg::ST_W-1:0];
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_q <= '0;
        end else begin
            status_q <= keepV | setV;
        end
    end

    // Interrupt from flags and enables, registered
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |((keepV | setV) & irqEn_q);
        end
    end

    // -------------------------------------------------------------------------
    // Read data and pin
    // -------------------------------------------------------------------------
    // Sampled in the second state, so a capture in the first state is seen
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (link.busSecond && !link.busWe) begin
            case (link.busAddr)
                ptu_pkg::DEV_CTRL:   rdata_q <= 16'(ctrl_q);
                ptu_pkg::DEV_COUNT:  rdata_q <= count_q;
                ptu_pkg::DEV_MATCH:  rdata_q <= match_q;
                ptu_pkg::DEV_BUFFER: rdata_q <= buffer_q;
                ptu_pkg::DEV_STATUS: rdata_q <= 16'(status_q);
                ptu_pkg::DEV_IRQEN:  rdata_q <= 16'(irqEn_q);
                default:             rdata_q <= '0;
            endcase
        end
    end

    // Match output toggles on every compare match
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pinOut_q <= 1'b0;
            pinOe_q  <= 1'b0;
        end else begin
            pinOe_q <= ctrl_q[ptu_pkg::CTL_PIN_OE];
            if (matchEv) begin
                pinOut_q <= !pinOut_q;
            end
        end
    end

    assign link.busRdata   = rdata_q;
    assign link.matchPinOut = pinOut_q;
    assign link.matchPinOe  = pinOe_q;
    assign link.chanIrq     = irq_q;
endmodule // ptu_dev_end

// File: ptu_host_end.sv
// Purpose : Wishbone-controlled bus master and pin driver for the timer channel
// Assumes : Classic Wishbone single cycles, 32-bit data, ack one cycle after request
// Notes   : Software sets clock pins by register, so pulse widths are its duty
`timescale 1ns/1ns
module ptu_host_end (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [ptu_pkg::WBW-1:0] wb_dat_i,
    output logic      [ptu_pkg::WBW-1:0] wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         irq,
    ptu_link_if.host                     link
);
    typedef enum logic [1:0] {PTU_IDLE, PTU_FIRST, PTU_SECOND, PTU_DONE} ptu_state_t;

    ptu_state_t               state_q;
    logic                     ack_q;
    logic [ptu_pkg::WBW-1:0]  dat_q;
    logic                     cmdWe_q;
    logic [ptu_pkg::AW-1:0]   cmdAdr_q;
    logic [ptu_pkg::DW-1:0]   wdata_q;
    logic [ptu_pkg::DW-1:0]   rdata_q;
    logic [ptu_pkg::IRQ_W-1:0] istat_q;
    logic [ptu_pkg::IRQ_W-1:0] imask_q;
    logic [ptu_pkg::PIN_W-1:0] pins_q;
    logic                     irq_q;
    logic                     devIrqPrev_q;
    logic                     req;
    logic                     wr;
    logic                     goWr;

    assign req  = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr   = req && wb_we_i && wb_sel_i[0];
    assign goWr = wr && (wb_adr_i == ptu_pkg::WB_CMD) && wb_dat_i[ptu_pkg::CMD_GO]
               && (state_q == PTU_IDLE);

    // -------------------------------------------------------------------------
    // Wishbone slave
    // -------------------------------------------------------------------------
    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= req;
            case (wb_adr_i)
                ptu_pkg::WB_RDATA: dat_q <= 32'(rdata_q);
                ptu_pkg::WB_WDATA: dat_q <= 32'(wdata_q);
                ptu_pkg::WB_ISTAT: dat_q <= 32'(istat_q);
                ptu_pkg::WB_IMASK: dat_q <= 32'(imask_q);
                ptu_pkg::WB_PINS:  dat_q <= 32'(pins_q);
                ptu_pkg::WB_STATE: dat_q <= {30'h0, link.chanIrq, state_q != PTU_IDLE};
                default:           dat_q <= '0;
            endcase
        end
    end

    // Command words and pin levels
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmdWe_q  <= 1'b0;
            cmdAdr_q <= '0;
            wdata_q  <= '0;
            imask_q  <= '0;
            pins_q   <= '0;
        end else if (wr) begin
            if (goWr) begin
                cmdWe_q  <= wb_dat_i[ptu_pkg::CMD_WE];
                cmdAdr_q <= wb_dat_i[ptu_pkg::CMD_ADR_LO +: ptu_pkg::AW];
            end
            if (wb_adr_i == ptu_pkg::WB_WDATA) begin
                wdata_q <= wb_dat_i[ptu_pkg::DW-1:0];
            end
            if (wb_adr_i == ptu_pkg::WB_IMASK) begin
                imask_q <= wb_dat_i[ptu_pkg::IRQ_W-1:0];
            end
            if (wb_adr_i == ptu_pkg::WB_PINS) begin
                pins_q[ptu_pkg::PIN_CAP:ptu_pkg::PIN_A] <= wb_dat_i[ptu_pkg::PIN_CAP:0];
                // Stop is refused while the channel still requests an interrupt
                if (!wb_dat_i[ptu_pkg::PIN_STOP] || !link.chanIrq) begin
                    pins_q[ptu_pkg::PIN_STOP] <= wb_dat_i[ptu_pkg::PIN_STOP];
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // Two-state access sequencer
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= PTU_IDLE;
            rdata_q <= '0;
        end else begin
            case (state_q)
                PTU_IDLE:   state_q <= goWr ? PTU_FIRST : PTU_IDLE;
                PTU_FIRST:  state_q <= PTU_SECOND;
                PTU_SECOND: state_q <= PTU_DONE;
                PTU_DONE: begin
                    if (!cmdWe_q) begin
                        rdata_q <= link.busRdata;
                    end
                    state_q <= PTU_IDLE;
                end
                default:    state_q <= PTU_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Interrupt
    // -------------------------------------------------------------------------
    // Write one to clear; a new event in the same cycle still sets
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            istat_q      <= '0;
            devIrqPrev_q <= 1'b0;
            irq_q        <= 1'b0;
        end else begin
            devIrqPrev_q <= link.chanIrq;
            istat_q <= (istat_q & ~((wr && wb_adr_i == ptu_pkg::WB_ISTAT)
                                     ? wb_dat_i[ptu_pkg::IRQ_W-1:0] : 2'h0))
                     | {link.chanIrq && !devIrqPrev_q, state_q == PTU_DONE};
            irq_q <= |(istat_q & imask_q);
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign irq      = irq_q;
    assign link.busFirst  = (state_q == PTU_FIRST);
    assign link.busSecond = (state_q == PTU_SECOND);
    assign link.busWe     = cmdWe_q;
    assign link.busAddr   = cmdAdr_q;
    assign link.busWdata  = wdata_q;
    // Clock pin held at zero while the channel drives its match output on it
    assign link.extClockInA = pins_q[ptu_pkg::PIN_A] && !link.matchPinOe;
    assign link.extClockInB = pins_q[ptu_pkg::PIN_B];
    assign link.captureIn   = pins_q[ptu_pkg::PIN_CAP];
    assign link.moduleStop  = pins_q[ptu_pkg::PIN_STOP];
endmodule // ptu_host_end

// File: ptu_link_props.sv
// Purpose : Checks on the link between timer channel and controller
// Assumes : One clock, rst active high
// Notes   : Sees the link signals only
`timescale 1ns/1ns
module ptu_link_props (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        busFirst,
    input wire logic        busSecond,
    input wire logic        busWe,
    input wire logic [2:0]  busAddr,
    input wire logic [15:0] busWdata,
    input wire logic [15:0] busRdata,
    input wire logic        moduleStop,
    input wire logic        matchPinOut,
    input wire logic        chanIrq
);
    // --------
    // Link rules
    // --------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    property p_first; busFirst |=> busSecond && !busFirst; endproperty
    a_first: assert property (p_first) else $error("no second state");
    property p_second; busSecond |-> $past(busFirst); endproperty
    a_second: assert property (p_second) else $error("lone second state");
    property p_hold; busFirst |=> $stable({busWe, busAddr, busWdata}); endproperty
    a_hold: assert property (p_hold) else $error("request moved");
    // Read data may only move right after a second state
    property p_rdata; $changed(busRdata) |-> $past(busSecond); endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved");
    // Enables cleared: request low two cycles on, it is registered
    property p_irqoff; busSecond && busWe && busAddr == 3'h5 && busWdata[2:0] == 3'h0
        |-> ##2 !chanIrq; endproperty
    a_irqoff: assert property (p_irqoff) else $error("request stayed");
    property p_stop; $rose(moduleStop) |-> !$past(chanIrq); endproperty
    a_stop: assert property (p_stop) else $error("stop with request");
    property p_once; $changed(matchPinOut) |=> $stable(matchPinOut); endproperty
    a_once: assert property (p_once) else $error("double match");
    property p_frozen; moduleStop [*3] |-> $stable(matchPinOut); endproperty
    a_frozen: assert property (p_frozen) else $error("match while stopped");
    property p_matchwr; busSecond && busWe && busAddr == ptu_pkg::DEV_MATCH
        |=> $stable(matchPinOut); endproperty
    a_matchwr: assert property (p_matchwr) else $error("match beside write");
endmodule // ptu_link_props

// File: timer_pulse_unit_contention_test.sv
// Purpose : Wishbone-driven test of both link ends
// Assumes : Each read queues its {mask, value} before the request
// Notes   : Exact second-state races are left to the checker
`timescale 1ns/1ns
module timer_pulse_unit_contention_test;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        wbCyc = 1'b0;
    logic        wbStb = 1'b0;
    logic        wbWe = 1'b0;
    logic [7:0]  wbAdr = 8'h00;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic        wbAck;
    logic        irq;
    logic [15:0] r;
    logic [63:0] note;
    logic [63:0] expQ[$];
    int          nMismatch = 0;
    int          checksDone = 0;
    ptu_link_if link ();
    ptu_dev_end ptu_dev_end_i (.ref_clk(ref_clk), .rst(rst), .link(link));
    ptu_host_end ptu_host_end_i (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .irq(irq), .link(link));
    ptu_link_props ptu_link_props_i (.ref_clk(ref_clk), .rst(rst), .busFirst(link.busFirst),
        .busSecond(link.busSecond), .busWe(link.busWe), .busAddr(link.busAddr),
        .busWdata(link.busWdata), .busRdata(link.busRdata), .moduleStop(link.moduleStop),
        .matchPinOut(link.matchPinOut), .chanIrq(link.chanIrq));
    // --------
    // Clock, tasks, monitor
    // --------
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hold the whole request until ack is sampled, then release
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [63:0] nt);
        @(posedge ref_clk);
        if (!we) begin
            expQ.push_back(nt);
        end
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        do begin
            @(posedge ref_clk);
        end while (wbAck !== 1'b1);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 64'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0, {m, e});
    endtask
    // Device access: four link cycles, then busy must be clear
    task automatic dx(input logic we, input logic [2:0] i, input logic [15:0] d);
        wr(8'h04, {16'h0, d});
        wr(8'h00, {27'h0, i, we, 1'b1});
        repeat (4) @(posedge ref_clk);
        rd(8'h18, 32'h1, 32'h0);
    endtask
    task automatic dw(input logic [2:0] i, input logic [15:0] d);
        dx(1'b1, i, d);
    endtask
    task automatic dr(input logic [2:0] i, input logic [15:0] m, input logic [15:0] e);
        dx(1'b0, i, 16'h0);
        rd(8'h08, {16'h0, m}, {16'h0, e});
    endtask
    // Pin pulse spans two Wishbone writes, many cycles wide
    task automatic pls(input logic [31:0] b, input logic [31:0] p);
        wr(8'h14, b | p);
        wr(8'h14, b);
    endtask
    // Each read answer takes the oldest note
    always @(posedge ref_clk) begin
        if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) begin
            note = expQ.pop_front();
            if (note[63:32] != 32'h0) begin
                chk(wbDatR & note[63:32], note[31:0]);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        nMismatch++;
        completeRun();
    end
    // --------
    // Scenarios
    // --------
    initial begin
        void'($urandom(32'h84DC2464));
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        dr(3'h2, 16'hFFFF, ptu_pkg::MATCH_RST);
        dr(3'h1, 16'hFFFF, ptu_pkg::CNT_ZERO);
        rd(8'h1C, 32'hFFFFFFFF, 32'h0);
        r = 16'($urandom);
        dw(3'h2, r);
        dr(3'h2, 16'hFFFF, r);
        // Clear on match with N = 2 gives a period of three edges
        dw(3'h2, 16'h2);
        dw(3'h5, 16'h1);
        dw(3'h0, 16'h0109);
        wr(8'h10, 32'h2);
        for (int k = 1; k <= 3; k++) begin
            pls(32'h0, 32'h1);
            dr(3'h1, 16'hFFFF, 16'(k % 3));
        end
        // Request follows flag and enable; stop is refused meanwhile
        dr(3'h4, 16'h7, 16'h1);
        rd(8'h18, 32'h2, 32'h2);
        wr(8'h14, 32'h8);
        rd(8'h14, 32'h8, 32'h0);
        chk({31'h0, irq}, 32'h1);
        wr(8'h10, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        dw(3'h5, 16'h0);
        rd(8'h18, 32'h2, 32'h0);
        dw(3'h5, 16'h1);
        dw(3'h4, 16'h0);
        rd(8'h18, 32'h2, 32'h0);
        wr(8'h0C, 32'h3);
        rd(8'h0C, 32'h2, 32'h0);
        dw(3'h5, 16'h0);
        // Down count at zero meets a clear: wrap flags untouched
        dw(3'h0, 16'h010D);
        dw(3'h2, 16'h0);
        dw(3'h4, 16'h0);
        pls(32'h0, 32'h1);
        dr(3'h1, 16'hFFFF, 16'h0);
        dr(3'h4, 16'h6, 16'h0);
        dw(3'h0, 16'h0105);
        pls(32'h0, 32'h1);
        dr(3'h1, 16'hFFFF, 16'hFFFF);
        dr(3'h4, 16'h6, 16'h4);
        // Capture takes the count, buffer the old match value
        dw(3'h0, 16'h0161);
        dw(3'h1, 16'h0123);
        dw(3'h2, 16'h0456);
        pls(32'h0, 32'h4);
        dr(3'h2, 16'hFFFF, 16'h0123);
        dr(3'h3, 16'hFFFF, 16'h0456);
        pls(32'h8, 32'h1);
        dr(3'h1, 16'hFFFF, 16'h0123);
        wr(8'h14, 32'h0);
        // Both edges count twice; A leading B counts up four
        dw(3'h1, 16'h0);
        dw(3'h0, 16'h0102);
        pls(32'h0, 32'h1);
        dr(3'h1, 16'hFFFF, 16'h2);
        dw(3'h0, 16'h0103);
        wr(8'h14, 32'h1);
        wr(8'h14, 32'h3);
        wr(8'h14, 32'h2);
        wr(8'h14, 32'h0);
        dr(3'h1, 16'hFFFF, 16'h6);
        completeRun();
    end
endmodule // timer_pulse_unit_contention_test
